// ===== include/sc_host_defs.svh
// constants of the smart-card host port: address, field positions, resets and timing
`ifndef SC_HOST_DEFS_SVH
`define SC_HOST_DEFS_SVH

`define ADDR_BYTE_BASE 8'h40
`define ADDR_SEL_DEFAULT 3'h4
`define CTRL_RST 8'h00
`define STAT_RST 8'h04
// idle pin levels: bus and relay lines high, straps at their default 1,0,0
`define PIN_IDLE 16'hFC13

`define CTRL_RUN_BIT 0
`define CTRL_WARM_BIT 1
`define STAT_IO_BIT 2

`define CLK_PERIOD_NS 10
`define T_VCC_RAMP_NS 2000
`define T_DEACT_NS 1000
`define VCC_RAMP_CYC ((`T_VCC_RAMP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEACT_CYC ((`T_DEACT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_LOW_CCLK 400
`define ATR_EARLY_CCLK 400
`define ATR_MUTE_CCLK 40000

`endif

// ===== include/sc_host_pkg.sv
// types shared by the smart-card host port
package sc_host_pkg;
  typedef struct packed {
    logic io_pass_en;
    logic card_clk_div_hi;
    logic card_clk_div_lo;
    logic clk_stop_high;
    logic clk_stop;
    logic vcc_3v;
    logic warm_reset;
    logic session_run;
  } host_control_t;

  typedef struct packed {
    logic session_powered;
    logic premature_answer;
    logic no_answer_timeout;
    logic overload_fault;
    logic supply_fault_latch;
    logic io_high;
    logic insert_change_latch;
    logic card_inserted;
  } host_status_t;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000, I2C_ADDR = 3'b001, I2C_ADDR_ACK = 3'b010, I2C_WRITE = 3'b011,
    I2C_WRITE_ACK = 3'b100, I2C_READ = 3'b101, I2C_READ_ACK = 3'b110, I2C_HOLD = 3'b111
  } i2c_state_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b000, SEQ_POWER = 3'b001, SEQ_RST_LOW = 3'b010,
    SEQ_ATR = 3'b011, SEQ_ACTIVE = 3'b100, SEQ_DEACT = 3'b101
  } seq_state_t;

  typedef enum logic [1:0] {
    OWN_NONE = 2'b00, OWN_HOST = 2'b01, OWN_CARD = 2'b10
  } line_owner_t;
endpackage

// ===== src/smartcard_iface_host_regs.sv
// smart-card interface host port: serial slave, control/status, sequencer, clock, relay
`timescale 1ns/10ps
`include "sc_host_defs.svh"

module smartcard_iface_host_regs
  import sc_host_pkg::*;
#(
  parameter logic [15:0] VCC_RAMP_CYC = 16'(`VCC_RAMP_CYC),
  parameter logic [15:0] DEACT_CYC = 16'(`DEACT_CYC),
  parameter logic [15:0] RST_LOW_CCLK = 16'(`RST_LOW_CCLK),
  parameter logic [15:0] EARLY_CCLK = 16'(`ATR_EARLY_CCLK),
  parameter logic [15:0] MUTE_CCLK = 16'(`ATR_MUTE_CCLK)
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // serial host bus, open drain data
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // address select straps
  input wire logic addr_select_0,
  input wire logic addr_select_1,
  input wire logic addr_select_2,
  // card detect, fault sensors and oscillator
  input wire logic card_detect,
  input wire logic supply_fault_in,
  input wire logic overcurrent_in,
  input wire logic overheat_in,
  input wire logic osc_input,
  // host side relay lines
  input wire logic host_card_data_in,
  output logic host_card_data_out,
  output logic host_card_data_oe_n,
  input wire logic host_aux_line_1_in,
  output logic host_aux_line_1_out,
  output logic host_aux_line_1_oe_n,
  input wire logic host_aux_line_2_in,
  output logic host_aux_line_2_out,
  output logic host_aux_line_2_oe_n,
  // card side relay lines
  input wire logic card_io_in,
  output logic card_io_out,
  output logic card_io_oe_n,
  input wire logic card_aux_line_1_in,
  output logic card_aux_line_1_out,
  output logic card_aux_line_1_oe_n,
  input wire logic card_aux_line_2_in,
  output logic card_aux_line_2_out,
  output logic card_aux_line_2_oe_n,
  // card power, reset and clock
  output logic card_vcc_on,
  output logic card_vcc_3v,
  output logic card_rst,
  output logic card_clk,
  // host interrupt
  output logic host_irq_n
);

  localparam int NPIN = 16;
  localparam int P_SCL = 0;
  localparam int P_SDA = 1;
  localparam int P_SEL = 2;
  localparam int P_DET = 5;
  localparam int P_SUP = 6;
  localparam int P_OC = 7;
  localparam int P_OH = 8;
  localparam int P_OSC = 9;
  localparam int P_HOST = 10;
  localparam int P_CARD = 13;

  // half-period length in oscillator edges for the card clock rate pair {bit5, bit6}
  function automatic logic [3:0] rate_half_edges(input logic sel_a, input logic sel_b);
    logic [3:0] n;
    n = 4'h8;
    case ({sel_a, sel_b})
      2'b00: n = 4'h8;
      2'b01: n = 4'h4;
      2'b11: n = 4'h2;
      2'b10: n = 4'h1;
      default: n = 4'h8;
    endcase
    return n;
  endfunction

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] sync1_r;
  logic [NPIN-1:0] sync2_r;
  logic [NPIN-1:0] sync3_r;
  logic [NPIN-1:0] pin_r;
  logic [2:0] addr_sel_r;
  logic scl_prev_r;
  logic sda_prev_r;
  i2c_state_t i2c_st_r;
  logic [2:0] bit_cnt_r;
  logic byte_done_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] snap_r;
  logic rw_r;
  logic sda_oe_n_r;
  host_control_t ctrl_r;
  host_status_t status_r;
  host_status_t status_nxt;
  logic irq_n_r;
  seq_state_t seq_r;
  logic [15:0] seq_cnt_r;
  logic [15:0] cclk_cnt_r;
  logic run_prev_r;
  logic vcc_on_r;
  logic rst_r;
  logic clk_en_r;
  logic warm_done_r;
  logic set_early_r;
  logic set_mute_r;
  logic session_start_r;
  logic osc_prev_r;
  logic [3:0] edge_cnt_r;
  logic cclk_free_r;
  logic card_clk_r;
  logic card_clk_prev_r;
  logic present_prev_r;
  logic [2:0] host_oe_n_r;
  logic [2:0] card_oe_n_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_match;
  logic ctrl_load;
  logic status_read;
  logic cclk_rise;
  logic fault_any;

  assign pin_raw = {card_aux_line_2_in, card_aux_line_1_in, card_io_in,
                    host_aux_line_2_in, host_aux_line_1_in, host_card_data_in,
                    osc_input, overheat_in, overcurrent_in, supply_fault_in, card_detect,
                    addr_select_2, addr_select_1, addr_select_0, sda_in, scl_in};

  // three-stage synchroniser; a level is taken once stages two and three agree
  // stages reset to the idle pin levels so no false edge follows reset
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_r <= `PIN_IDLE;
      sync2_r <= `PIN_IDLE;
      sync3_r <= `PIN_IDLE;
      pin_r <= `PIN_IDLE;
    end
    else
    begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      pin_r <= (sync2_r & sync3_r) | (pin_r & (sync2_r ^ sync3_r));
    end
  end

  // straps read the reset default until the pins are sampled after release
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      addr_sel_r <= `ADDR_SEL_DEFAULT;
    else
      addr_sel_r <= pin_r[P_SEL+2:P_SEL];
  end

  // bus edge and condition detection on the filtered levels
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      scl_prev_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end
    else
    begin
      scl_prev_r <= pin_r[P_SCL];
      sda_prev_r <= pin_r[P_SDA];
    end
  end

  assign scl_rise = pin_r[P_SCL] & ~scl_prev_r;
  assign scl_fall = ~pin_r[P_SCL] & scl_prev_r;
  assign start_det = scl_prev_r & pin_r[P_SCL] & sda_prev_r & ~pin_r[P_SDA];
  assign stop_det = scl_prev_r & pin_r[P_SCL] & ~sda_prev_r & pin_r[P_SDA];
  assign addr_match = ({shift_r[7:1], 1'b0} == (`ADDR_BYTE_BASE + {4'h0, addr_sel_r, 1'b0}));
  assign ctrl_load = (i2c_st_r == I2C_WRITE) && scl_fall && byte_done_r;
  assign status_read = (i2c_st_r == I2C_READ_ACK) && scl_rise;

  // serial slave; data changes only while the clock is low so it never fakes a start
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      i2c_st_r <= I2C_IDLE;
      bit_cnt_r <= 3'h0;
      byte_done_r <= 1'b0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      snap_r <= 8'h00;
      rw_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end
    else if (start_det)
    begin
      i2c_st_r <= I2C_ADDR;
      bit_cnt_r <= 3'h0;
      byte_done_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
    end
    else if (stop_det)
    begin
      i2c_st_r <= I2C_IDLE;
      sda_oe_n_r <= 1'b1;
    end
    else
    begin
      case (i2c_st_r)
        I2C_ADDR, I2C_WRITE:
        begin
          if (scl_rise)
          begin
            shift_r <= {shift_r[6:0], pin_r[P_SDA]};
            bit_cnt_r <= bit_cnt_r + 3'h1;
            byte_done_r <= (bit_cnt_r == 3'h7);
          end
          else if (scl_fall && byte_done_r)
          begin
            byte_done_r <= 1'b0;
            if (i2c_st_r == I2C_WRITE)
            begin
              sda_oe_n_r <= 1'b0;
              i2c_st_r <= I2C_WRITE_ACK;
            end
            else if (addr_match)
            begin
              sda_oe_n_r <= 1'b0;
              rw_r <= shift_r[0];
              i2c_st_r <= I2C_ADDR_ACK;
            end
            else
              i2c_st_r <= I2C_HOLD;
          end
        end
        I2C_ADDR_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_r <= 3'h0;
            if (rw_r)
            begin
              // snapshot status and present its top bit
              tx_r <= status_r;
              snap_r <= status_r;
              sda_oe_n_r <= status_r[7];
              i2c_st_r <= I2C_READ;
            end
            else
            begin
              sda_oe_n_r <= 1'b1;
              i2c_st_r <= I2C_WRITE;
            end
          end
        end
        I2C_READ:
        begin
          if (scl_rise)
          begin
            bit_cnt_r <= bit_cnt_r + 3'h1;
            byte_done_r <= (bit_cnt_r == 3'h7);
          end
          else if (scl_fall)
          begin
            if (byte_done_r)
            begin
              // release for the master's answer bit
              byte_done_r <= 1'b0;
              sda_oe_n_r <= 1'b1;
              i2c_st_r <= I2C_READ_ACK;
            end
            else
            begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_n_r <= tx_r[6];
            end
          end
        end
        I2C_WRITE_ACK:
        begin
          if (scl_fall)
          begin
            sda_oe_n_r <= 1'b1;
            i2c_st_r <= I2C_HOLD;
          end
        end
        I2C_READ_ACK:
        begin
          if (scl_rise)
            i2c_st_r <= I2C_HOLD;
        end
        default:
        begin
          sda_oe_n_r <= 1'b1;
        end
      endcase
    end
  end

  // control register; a host write wins over the warm reset self-clear
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrl_r <= host_control_t'(`CTRL_RST);
    else if (ctrl_load)
      ctrl_r <= host_control_t'(shift_r);
    else if (warm_done_r)
      ctrl_r.warm_reset <= 1'b0;
  end

  assign fault_any = pin_r[P_SUP] | pin_r[P_OC] | pin_r[P_OH];
  assign cclk_rise = card_clk_r & ~card_clk_prev_r;

  // activation sequencer; faults and removal always force deactivation
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seq_r <= SEQ_IDLE;
      seq_cnt_r <= 16'h0000;
      cclk_cnt_r <= 16'h0000;
      run_prev_r <= 1'b0;
      vcc_on_r <= 1'b0;
      rst_r <= 1'b0;
      clk_en_r <= 1'b0;
      warm_done_r <= 1'b0;
      set_early_r <= 1'b0;
      set_mute_r <= 1'b0;
      session_start_r <= 1'b0;
    end
    else
    begin
      run_prev_r <= ctrl_r.session_run;
      warm_done_r <= 1'b0;
      set_early_r <= 1'b0;
      set_mute_r <= 1'b0;
      session_start_r <= 1'b0;
      seq_cnt_r <= seq_cnt_r + 16'h0001;
      if (cclk_rise)
        cclk_cnt_r <= cclk_cnt_r + 16'h0001;
      if (seq_r != SEQ_IDLE && seq_r != SEQ_DEACT &&
          (!ctrl_r.session_run || fault_any || !pin_r[P_DET]))
      begin
        // deactivate on stop, fault or removal
        seq_r <= SEQ_DEACT;
        seq_cnt_r <= 16'h0000;
        rst_r <= 1'b0;
        clk_en_r <= 1'b0;
      end
      else
      begin
        case (seq_r)
          SEQ_IDLE:
          begin
            vcc_on_r <= 1'b0;
            // launch activation on a set of the run bit
            if (ctrl_r.session_run && !run_prev_r && pin_r[P_DET] && !fault_any)
            begin
              seq_r <= SEQ_POWER;
              seq_cnt_r <= 16'h0000;
              vcc_on_r <= 1'b1;
              session_start_r <= 1'b1;
            end
          end
          SEQ_POWER:
          begin
            if (seq_cnt_r >= VCC_RAMP_CYC)
            begin
              seq_r <= SEQ_RST_LOW;
              clk_en_r <= 1'b1;
              cclk_cnt_r <= 16'h0000;
            end
          end
          SEQ_RST_LOW:
          begin
            if (cclk_cnt_r >= RST_LOW_CCLK)
            begin
              seq_r <= SEQ_ATR;
              rst_r <= 1'b1;
              cclk_cnt_r <= 16'h0000;
            end
          end
          SEQ_ATR:
          begin
            if (!pin_r[P_CARD])
            begin
              set_early_r <= (cclk_cnt_r < EARLY_CCLK);
              warm_done_r <= 1'b1;
              seq_r <= SEQ_ACTIVE;
            end
            else if (cclk_cnt_r >= MUTE_CCLK)
            begin
              set_mute_r <= 1'b1;
              warm_done_r <= 1'b1;
              seq_r <= SEQ_ACTIVE;
            end
          end
          SEQ_ACTIVE:
          begin
            // warm reset of the active card
            if (ctrl_r.warm_reset && !warm_done_r)
            begin
              seq_r <= SEQ_RST_LOW;
              rst_r <= 1'b0;
              cclk_cnt_r <= 16'h0000;
            end
          end
          SEQ_DEACT:
          begin
            if (seq_cnt_r >= DEACT_CYC)
            begin
              vcc_on_r <= 1'b0;
              seq_r <= SEQ_IDLE;
            end
          end
          default:
          begin
            seq_r <= SEQ_IDLE;
          end
        endcase
      end
    end
  end

  // card clock divider from the filtered oscillator; only valid for oscillators
  // well below a quarter of sys_clk because of the synchroniser sampling
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      osc_prev_r <= 1'b0;
      edge_cnt_r <= 4'h0;
      cclk_free_r <= 1'b0;
      card_clk_r <= 1'b0;
      card_clk_prev_r <= 1'b0;
    end
    else
    begin
      osc_prev_r <= pin_r[P_OSC];
      card_clk_prev_r <= card_clk_r;
      if (pin_r[P_OSC] != osc_prev_r)
      begin
        if (edge_cnt_r + 4'h1 >= rate_half_edges(ctrl_r.card_clk_div_lo, ctrl_r.card_clk_div_hi))
        begin
          edge_cnt_r <= 4'h0;
          cclk_free_r <= ~cclk_free_r;
        end
        else
          edge_cnt_r <= edge_cnt_r + 4'h1;
      end
      // stop the clock at the chosen level; a stop mid-pulse may shorten it
      if (!clk_en_r)
        card_clk_r <= 1'b0;
      else if (ctrl_r.clk_stop && seq_r == SEQ_ACTIVE)
        card_clk_r <= ctrl_r.clk_stop_high;
      else
        card_clk_r <= cclk_free_r;
    end
  end

  // status bits; a new event in the clearing cycle keeps its bit set
  always_comb
  begin
    status_nxt = status_r;
    status_nxt.card_inserted = pin_r[P_DET];
    status_nxt.io_high = pin_r[P_CARD];
    status_nxt.session_powered = vcc_on_r;
    if (status_read)
      status_nxt = status_nxt & ~(host_status_t'(snap_r) & 8'h7A);
    if (session_start_r)
    begin
      status_nxt.no_answer_timeout = 1'b0;
      status_nxt.premature_answer = 1'b0;
    end
    if (pin_r[P_DET] != present_prev_r)
      status_nxt.insert_change_latch = 1'b1;
    if (pin_r[P_SUP])
      status_nxt.supply_fault_latch = 1'b1;
    if ((pin_r[P_OC] | pin_r[P_OH]) && seq_r != SEQ_IDLE)
      status_nxt.overload_fault = 1'b1;
    if (set_mute_r)
      status_nxt.no_answer_timeout = 1'b1;
    if (set_early_r)
      status_nxt.premature_answer = 1'b1;
  end

  // status register and interrupt line
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_r <= host_status_t'(`STAT_RST);
      present_prev_r <= 1'b0;
      irq_n_r <= 1'b1;
    end
    else
    begin
      status_r <= status_nxt;
      present_prev_r <= pin_r[P_DET];
      // interrupt while the insert-change, supply-fault or overload bit is set
      irq_n_r <= ~(status_r.insert_change_latch | status_r.supply_fault_latch |
                   status_r.overload_fault);
    end
  end

  // bidirectional relay; the first side to pull low owns the line until both are high
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_relay
      line_owner_t own_r;
      logic host_low;
      logic card_low;
      assign host_low = ~pin_r[P_HOST+gi];
      assign card_low = ~pin_r[P_CARD+gi];
      always_ff @(posedge sys_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          own_r <= OWN_NONE;
          host_oe_n_r[gi] <= 1'b1;
          card_oe_n_r[gi] <= 1'b1;
        end
        // relay off leaves both sides floating
        else if (!ctrl_r.io_pass_en)
        begin
          own_r <= OWN_NONE;
          host_oe_n_r[gi] <= 1'b1;
          card_oe_n_r[gi] <= 1'b1;
        end
        else
        begin
          case (own_r)
            OWN_NONE:
            begin
              if (host_low)
                own_r <= OWN_HOST;
              else if (card_low)
                own_r <= OWN_CARD;
            end
            OWN_HOST:
            begin
              if (!host_low && !card_low)
                own_r <= OWN_NONE;
            end
            OWN_CARD:
            begin
              if (!host_low && !card_low)
                own_r <= OWN_NONE;
            end
            default:
            begin
              own_r <= OWN_NONE;
            end
          endcase
          card_oe_n_r[gi] <= ~((own_r == OWN_HOST || (own_r == OWN_NONE && host_low)) && host_low);
          host_oe_n_r[gi] <= ~(own_r == OWN_CARD && card_low);
        end
      end
    end
  endgenerate

  // open-drain pins only ever drive low
  assign sda_out = 1'b0;
  assign sda_oe_n = sda_oe_n_r;
  assign host_card_data_out = 1'b0;
  assign host_aux_line_1_out = 1'b0;
  assign host_aux_line_2_out = 1'b0;
  assign card_io_out = 1'b0;
  assign card_aux_line_1_out = 1'b0;
  assign card_aux_line_2_out = 1'b0;
  assign host_card_data_oe_n = host_oe_n_r[0];
  assign host_aux_line_1_oe_n = host_oe_n_r[1];
  assign host_aux_line_2_oe_n = host_oe_n_r[2];
  assign card_io_oe_n = card_oe_n_r[0];
  assign card_aux_line_1_oe_n = card_oe_n_r[1];
  assign card_aux_line_2_oe_n = card_oe_n_r[2];
  // card power and control, host interrupt
  assign card_vcc_on = vcc_on_r;
  assign card_vcc_3v = ctrl_r.vcc_3v;
  assign card_rst = rst_r;
  assign card_clk = card_clk_r;
  assign host_irq_n = irq_n_r;

endmodule

// ===== verif/sc_host_checker_assertions.sv
// pin-level checks of the smart-card host port
`timescale 1ns/10ps

module sc_host_checker (
  // clock, reset and serial bus
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // sensors
  input wire logic card_detect,
  input wire logic supply_fault_in,
  input wire logic overcurrent_in,
  // relay, card and interrupt
  input wire logic card_io_oe_n,
  input wire logic host_card_data_oe_n,
  input wire logic card_vcc_on,
  input wire logic card_rst,
  input wire logic card_clk,
  input wire logic host_irq_n
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  // card stays in reset for at least 8 cycles after the supply switches on
  sequence s_rst_held;
    !card_rst [*8];
  endsequence

  // open drain: data value is only ever low, sda moves only while scl is low
  property p_sda_low; sda_out == 1'b0; endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda drives high");
  property p_ack_edge; $changed(sda_oe_n) |-> !scl_in; endproperty
  a_ack_edge: assert property (p_ack_edge) else $error("sda moved with scl high");
  // relay pulls one side only, never both at once
  property p_relay_one; !card_io_oe_n |-> host_card_data_oe_n; endproperty
  a_relay_one: assert property (p_relay_one) else $error("relay pulls both sides");
  // session power-up and idle card lines
  property p_cold_rst; $rose(card_vcc_on) |-> s_rst_held; endproperty
  a_cold_rst: assert property (p_cold_rst) else $error("reset released early");
  property p_idle_card; !card_vcc_on |-> !card_clk && !card_rst; endproperty
  a_idle_card: assert property (p_idle_card) else $error("card lines live unpowered");
  // events reach the interrupt, and overload drops card reset, within the pin filter delay
  property p_det_irq; $changed(card_detect) |-> ##[1:8] !host_irq_n; endproperty
  a_det_irq: assert property (p_det_irq) else $error("no irq on presence edge");
  property p_sup_irq; $rose(supply_fault_in) |-> ##[1:8] !host_irq_n; endproperty
  a_sup_irq: assert property (p_sup_irq) else $error("no irq on supply fault");
  property p_oc_stop; $rose(overcurrent_in) && card_vcc_on |-> ##[1:8] !card_rst; endproperty
  a_oc_stop: assert property (p_oc_stop) else $error("no deactivation on overload");
endmodule

bind smartcard_iface_host_regs sc_host_checker chk_u (.sys_clk, .arst_n, .scl_in, .sda_out,
  .sda_oe_n, .card_detect, .supply_fault_in, .overcurrent_in, .card_io_oe_n,
  .host_card_data_oe_n, .card_vcc_on, .card_rst, .card_clk, .host_irq_n);

// ===== verif/i2c_host_model.sv
// serial bus master model standing in for the host controller
`timescale 1ns/10ps

module i2c_host_model (
  // clock and bus pins
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl = 1'b1,
  output logic sda = 1'b1
);
  // third of a bit far above the slave's pin filter delay
  localparam int Q = 10;

  task automatic qw;
    repeat (Q) @(posedge sys_clk);
    #1;
  endtask

  // data set in the low phase, sampled at the end of the high phase
  task automatic put_bit(input logic b, output logic r);
    sda = b;
    qw();
    scl = 1'b1;
    qw();
    r = sda_line;
    scl = 1'b0;
    qw();
  endtask

  task automatic xfer(input logic [7:0] ab, input logic [7:0] wd, output logic [7:0] rd,
      output logic [1:0] ack);
    logic r;
    sda = 1'b0;
    qw();
    scl = 1'b0;
    qw();
    for (int i = 7; i >= 0; i--)
      put_bit(ab[i], r);
    put_bit(1'b1, ack[1]);
    for (int i = 7; i >= 0; i--)
      put_bit(ab[0] | wd[i], rd[i]);
    // released on a write so the device ack is seen, high answer on a read
    put_bit(1'b1, ack[0]);
    sda = 1'b0;
    qw();
    scl = 1'b1;
    qw();
    sda = 1'b1;
    qw();
  endtask
endmodule

// ===== verif/smartcard_iface_host_regs_test.sv
// self-checking bench of the smart-card host port
`timescale 1ns/10ps

module smartcard_iface_host_regs_test;
  logic sys_clk, osc, arst_n = 1'b0, oh = 1'b0;
  logic det = 1'b0, sf = 1'b0, oc = 1'b0, scl, m_sda, sda_oe_n, cclk;
  logic [2:0] hd = 3'h7, cd = 3'h7;
  wire [2:0] hoe_n, coe_n;
  logic von, v3, crst, irq_n;
  logic [2:0] sel = 3'h4;
  logic [7:0] d, v;
  logic [1:0] a;
  logic [31:0] seed = 32'h3A5E6CE6;
  int err_total = 0, n_tests = 0;
  // pulled-up lines: low whenever any party pulls
  wire sda_line = m_sda & sda_oe_n;
  wire [2:0] hl = hd & hoe_n;
  wire [2:0] cl = cd & coe_n;

  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial
  begin
    osc = 1'b0;
    forever #50 osc = ~osc;
  end

  // short counts keep card sessions within a few thousand cycles
  smartcard_iface_host_regs #(.VCC_RAMP_CYC(16'h0004), .DEACT_CYC(16'h0004),
      .RST_LOW_CCLK(16'h0004), .EARLY_CCLK(16'h0008), .MUTE_CCLK(16'h0032)) dut_u (
    .sys_clk, .arst_n, .scl_in(scl), .sda_in(sda_line), .sda_out(), .sda_oe_n,
    .addr_select_0(sel[0]), .addr_select_1(sel[1]), .addr_select_2(sel[2]),
    .card_detect(det), .supply_fault_in(sf), .overcurrent_in(oc), .overheat_in(oh),
    .osc_input(osc), .host_card_data_in(hl[0]), .host_card_data_out(),
    .host_card_data_oe_n(hoe_n[0]),
    .host_aux_line_1_in(hl[1]), .host_aux_line_1_out(), .host_aux_line_1_oe_n(hoe_n[1]),
    .host_aux_line_2_in(hl[2]), .host_aux_line_2_out(), .host_aux_line_2_oe_n(hoe_n[2]),
    .card_io_in(cl[0]), .card_io_out(), .card_io_oe_n(coe_n[0]), .card_aux_line_1_in(cl[1]),
    .card_aux_line_1_out(), .card_aux_line_1_oe_n(coe_n[1]), .card_aux_line_2_in(cl[2]),
    .card_aux_line_2_out(), .card_aux_line_2_oe_n(coe_n[2]), .card_vcc_on(von),
    .card_vcc_3v(v3), .card_rst(crst), .card_clk(cclk), .host_irq_n(irq_n));

  i2c_host_model m_u (.sys_clk, .sda_line, .scl, .sda(m_sda));

  function automatic logic [7:0] addr_of(input logic [2:0] s, input logic rw);
    return 8'h40 + {4'h0, s, rw};
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // card clock high time in system cycles for rate pair {bit5, bit6}; osc half period is 5
  function automatic logic [7:0] half_of(input logic [1:0] ab);
    case (ab)
      2'b00: return 8'h28;
      2'b01: return 8'h14;
      2'b11: return 8'h0A;
      default: return 8'h05;
    endcase
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // high time measured from a fresh rising edge, so a rate change mid-pulse is skipped
  task automatic chk_half(input logic [1:0] ab);
    int n;
    n = 0;
    for (int k = 0; k < 200 && cclk !== 1'b0; k++)
      cyc(1);
    for (int k = 0; k < 200 && cclk !== 1'b1; k++)
      cyc(1);
    for (int k = 0; k < 200 && cclk !== 1'b0; k++)
    begin
      cyc(1);
      n++;
    end
    chk(n[7:0], half_of(ab));
  endtask
  task automatic wr(input logic [7:0] val);
    m_u.xfer(addr_of(sel, 1'b0), val, d, a);
    chk({6'h00, a}, 8'h00);
  endtask
  task automatic rd(input logic [7:0] exp);
    m_u.xfer(addr_of(sel, 1'b1), 8'hFF, d, a);
    chk({6'h00, a}, 8'h01);
    chk(d, exp);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // watchdog well above the expected run length
  initial
  begin
    repeat (80000) @(posedge sys_clk);
    err_total++;
    print_verdict();
  end

  initial
  begin
    cyc(10);
    arst_n = 1'b1;
    cyc(20);
    chk({7'h00, v3}, 8'h00);
    rd(8'h04);
    // each strap setting answers, its neighbour address stays silent
    for (int i = 0; i < 8; i++)
    begin
      sel = i[2:0];
      cyc(10);
      rd(8'h04);
      m_u.xfer(addr_of(sel ^ 3'h1, 1'b1), 8'hFF, d, a);
      chk({6'h00, a}, 8'h03);
    end
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr(seed);
      v = seed[7:0] & 8'hFC;
      wr(v);
      cyc(5);
      chk({7'h00, v3}, {7'h00, v[2]});
    end
    for (int j = 0; j < 2; j++)
    begin
      wr({j[0], 7'h00});
      hd = 3'h0;
      cyc(10);
      chk({5'h00, coe_n}, {5'h00, {3{~j[0]}}});
      hd = 3'h7;
      cyc(10);
      cd = 3'h0;
      cyc(10);
      chk({5'h00, hoe_n}, {5'h00, {3{~j[0]}}});
      cd = 3'h7;
      cyc(10);
    end
    wr(8'h00);
    det = 1'b1;
    cyc(20);
    chk({7'h00, irq_n}, 8'h00);
    rd(8'h07);
    rd(8'h05);
    chk({7'h00, irq_n}, 8'h01);
    sf = 1'b1;
    cyc(20);
    sf = 1'b0;
    rd(8'h0D);
    rd(8'h05);
    oh = 1'b1;
    cyc(20);
    oh = 1'b0;
    rd(8'h05);
    // silent card runs into the mute limit
    wr(8'h01);
    cyc(5500);
    rd(8'hA5);
    rd(8'h85);
    wr(8'h00);
    cyc(200);
    chk({7'h00, von}, 8'h00);
    // card answers right after reset release
    wr(8'h01);
    for (int k = 0; k < 3000 && crst !== 1'b1; k++)
      cyc(1);
    cd[0] = 1'b0;
    cyc(40);
    cd[0] = 1'b1;
    cyc(100);
    rd(8'hC5);
    // warm reset drops reset, the answer ends it and the bit clears itself
    wr(8'h03);
    cyc(20);
    chk({7'h00, crst}, 8'h00);
    for (int k = 0; k < 3000 && crst !== 1'b1; k++)
      cyc(1);
    cd[0] = 1'b0;
    cyc(40);
    cd[0] = 1'b1;
    cyc(200);
    chk({7'h00, crst}, 8'h01);
    rd(8'hC5);
    for (int r = 0; r < 4; r++)
    begin
      wr({1'b0, r[0], r[1], 5'h01});
      chk_half(r[1:0]);
    end
    wr(8'h19);
    cyc(10);
    chk({7'h00, cclk}, 8'h01);
    wr(8'h09);
    cyc(10);
    chk({7'h00, cclk}, 8'h00);
    oc = 1'b1;
    cyc(20);
    chk({7'h00, crst}, 8'h00);
    chk({7'h00, irq_n}, 8'h00);
    oc = 1'b0;
    cyc(200);
    rd(8'h15);
    print_verdict();
  end
endmodule
